// File: infrared_remote_receiver.sv
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module infrared_remote_receiver
  import ir_rx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [ir_rx_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ir_rx_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic remote_input_pin,
  input wire logic subclock_in,
  input wire logic low_power_hold,
  output logic irq
);
  import ir_rx_pkg::*;

  typedef struct packed {
    logic aw_seen;
    logic [14:0] aw_idx;
    logic w_seen;
    logic [7:0] w_byte;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] control;
    logic [3:0] flags;
    logic [3:0] enables;
    logic [7:0] shift;
    logic [7:0] data;
    logic [2:0] bit_counter;
    logic [1:0] guide_prescale_code;
    logic [1:0] data_prescale_code;
    logic suspend_resume_flag;
    logic [7:0] gpw;
    logic [7:0] zw;
    logic [7:0] ow;
    logic [6:0] xhw;
    rx_state_e state;
    logic [7:0] div_cnt;
    logic sub_prev;
    logic [4:0] width_prescaler;
    logic [4:0] pulse_width_counter;
    logic [4:0] mark_w;
    logic at_mid;
    logic run_prev;
    logic irq;
  } rx_s;

  rx_s q, d;
  logic base_tick;
  logic filt_restart;
  logic filt_level;
  logic filt_rise;
  logic filt_fall;

  function automatic logic [5:0] presc_period(input logic [1:0] code, input logic [2:0] fmt);
    logic [5:0] p;
    p = 6'h04 << code;
    if (fmt == FMT_D || fmt == FMT_E) begin
      p = 6'h02 << code;
    end
    return p;
  endfunction

  // window of plus or minus one count around the programmed width
  function automatic logic near(input logic [4:0] meas, input logic [4:0] prog);
    return ({1'b0, meas} + WIDTH_TOL >= {1'b0, prog}) &&
           ({1'b0, meas} <= {1'b0, prog} + WIDTH_TOL);
  endfunction

  function automatic logic [7:0] base_div(input logic [2:0] ck);
    logic [7:0] v;
    case (ck)
      3'h0: v = 8'h07;
      3'h1: v = 8'h0f;
      3'h2: v = 8'h1f;
      3'h3: v = 8'h3f;
      3'h4: v = 8'h7f;
      3'h5: v = 8'hff;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // base clock tick, from the divider flops or the live subclock_in and low_power_hold inputs, so the filter sees a clean strobe
  always_comb begin
    logic [2:0] ck;
    ck = q.control[CTL_CK_LSB +: 3];
    base_tick = 1'b0;
    if (q.control[CTL_RUN] && q.run_prev) begin
      if (ck == CK_SUBCLOCK) begin
        base_tick = q.sub_prev ^ subclock_in;
        base_tick = base_tick & subclock_in;
      end else if (!low_power_hold) begin
        // cycle clock is stopped in hold, so only the subclock keeps running
        base_tick = (q.div_cnt == base_div(ck));
      end
    end
  end

  assign filt_restart = q.control[CTL_RUN] & ~q.run_prev;

  ir_glitch_filter u_filter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sample_tick(base_tick),
    .restart(filt_restart),
    .raw_in(remote_input_pin ^ q.control[CTL_POL]),
    .level(filt_level),
    .rise(filt_rise),
    .fall(filt_fall)
  );

  always_comb begin
    logic [2:0] fmt;
    logic edge_seen;
    logic guide_phase;
    logic presc_pulse;
    logic [5:0] period;
    logic emit;
    logic emit_val;
    logic clear_rx;
    logic [3:0] set_f;
    logic [3:0] keep_f;
    logic [7:0] nshift;
    logic [4:0] gp_hi, gp_lo, d0h, d0l, d1h, d1l;
    logic wr_go;
    logic [7:0] wb;
    fmt = q.control[CTL_FMT_LSB +: 3];
    edge_seen = filt_rise | filt_fall;
    emit = 1'b0;
    emit_val = 1'b0;
    clear_rx = 1'b0;
    set_f = 4'h0;
    keep_f = 4'hf;
    nshift = 8'h00;
    wr_go = 1'b0;
    wb = q.w_byte;
    gp_hi = {q.xhw[XHW_GPH], q.gpw[7:4]};
    gp_lo = {q.xhw[XHW_GPL], q.gpw[3:0]};
    d0h = {q.xhw[XHW_D0H], q.zw[7:4]};
    d0l = {q.xhw[XHW_D0L], q.zw[3:0]};
    d1h = {q.xhw[XHW_D1H], q.ow[7:4]};
    d1l = {q.xhw[XHW_D1L], q.ow[3:0]};
    d = q;
    d.run_prev = q.control[CTL_RUN];
    d.sub_prev = subclock_in;

    // base clock divider
    if (!q.control[CTL_RUN] || q.div_cnt == base_div(q.control[CTL_CK_LSB +: 3])) begin
      d.div_cnt = 8'h00;
    end else if (!low_power_hold) begin
      d.div_cnt = q.div_cnt + 8'h01;
    end

    // prescaler and pulse width counter
    guide_phase = (q.state == ST_GUIDE_HI || q.state == ST_GUIDE_LO) &&
                  fmt != FMT_C && fmt != FMT_D;
    period = presc_period(guide_phase ? q.guide_prescale_code : q.data_prescale_code, fmt);
    presc_pulse = base_tick && (q.width_prescaler == 5'(period - 6'h01));
    if (edge_seen || q.state == ST_WAIT) begin
      d.width_prescaler = 5'h00;
      d.pulse_width_counter = 5'h00;
    end else begin
      if (base_tick) begin
        d.width_prescaler = presc_pulse ? 5'h00 : q.width_prescaler + 5'h01;
      end
      if (presc_pulse && q.pulse_width_counter != WIDTH_MAX) begin
        d.pulse_width_counter = q.pulse_width_counter + 5'h01;
      end
    end

    case (q.state)
      ST_IDLE: begin
        if (q.control[CTL_RUN]) begin
          d.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (filt_rise) begin
          if (fmt == FMT_C || fmt == FMT_D) begin
            clear_rx = 1'b1;
            d.at_mid = 1'b1;
            d.state = (fmt == FMT_C) ? ST_DATA_HI : ST_MAN;
          end else begin
            d.state = ST_GUIDE_HI;
          end
        end
      end
      ST_GUIDE_HI: begin
        if (filt_fall) begin
          if (!near(q.pulse_width_counter, gp_hi)) begin
            set_f[2] = 1'b1;
            d.state = ST_WAIT;
          end else if (fmt == FMT_A) begin
            // half clock guide: only the mark is judged
            set_f[3] = 1'b1;
            clear_rx = 1'b1;
            d.state = ST_GUIDE_LO;
          end else begin
            d.state = ST_GUIDE_LO;
          end
        end else if (q.pulse_width_counter == WIDTH_MAX) begin
          set_f[2] = 1'b1;
          d.state = ST_WAIT;
        end
      end
      ST_GUIDE_LO: begin
        if (filt_rise) begin
          if (fmt == FMT_A) begin
            d.state = ST_DATA_HI;
          end else if (near(q.pulse_width_counter, gp_lo)) begin
            set_f[3] = 1'b1;
            clear_rx = 1'b1;
            d.at_mid = 1'b1;
            d.state = (fmt == FMT_E) ? ST_MAN : ST_DATA_HI;
          end else begin
            set_f[2] = 1'b1;
            d.state = ST_WAIT;
          end
        end else if (q.pulse_width_counter == WIDTH_MAX) begin
          set_f[2] = 1'b1;
          d.state = ST_WAIT;
        end
      end
      ST_DATA_HI: begin
        if (filt_fall) begin
          d.mark_w = q.pulse_width_counter;
          d.state = ST_DATA_LO;
        end else if (q.pulse_width_counter == WIDTH_MAX) begin
          set_f[0] = 1'b1;
          d.state = ST_DONE;
        end
      end
      ST_DATA_LO: begin
        if (filt_rise) begin
          d.state = ST_DATA_HI;
          if (near(q.mark_w, d0h) && near(q.pulse_width_counter, d0l)) begin
            emit = 1'b1;
          end else if (near(q.mark_w, d1h) && near(q.pulse_width_counter, d1l)) begin
            emit = 1'b1;
            emit_val = 1'b1;
          end else begin
            set_f[2] = 1'b1;
            d.state = ST_WAIT;
          end
        end else if (q.pulse_width_counter == WIDTH_MAX) begin
          // stop mark or repeat code ends in a long space
          set_f[0] = 1'b1;
          d.state = ST_DONE;
        end
      end
      ST_MAN: begin
        if (edge_seen) begin
          if (near(q.pulse_width_counter, d0l)) begin
            d.at_mid = ~q.at_mid;
            emit = ~q.at_mid;
            emit_val = filt_level;
          end else if (near(q.pulse_width_counter, d1l) && q.at_mid) begin
            emit = 1'b1;
            emit_val = filt_level;
          end else begin
            set_f[2] = 1'b1;
            d.state = ST_WAIT;
          end
        end else if (q.pulse_width_counter == WIDTH_MAX) begin
          set_f[0] = 1'b1;
          d.state = ST_DONE;
        end
      end
      ST_DONE: begin
        // suspend flag parks the receiver until software clears it
        if (!q.suspend_resume_flag) begin
          d.state = ST_WAIT;
        end
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase

    if (clear_rx) begin
      d.shift = 8'h00;
      d.bit_counter = 3'h0;
    end
    if (emit) begin
      // the unused bit 6 is not stored, so direction sits one place lower in the copy
      nshift = q.xhw[XHW_DIR - 1] ? {q.shift[6:0], emit_val} : {emit_val, q.shift[7:1]};
      d.shift = nshift;
      d.bit_counter = q.bit_counter + 3'h1;
      if (q.bit_counter == 3'h7) begin
        d.data = nshift;
        d.shift = 8'h00;
        set_f[1] = 1'b1;
      end
    end
    if (!q.control[CTL_RUN]) begin
      d.state = ST_IDLE;
      d.shift = 8'h00;
      d.bit_counter = 3'h0;
      d.at_mid = 1'b0;
    end

    // AXI4-Lite write path
    if (s_axi_awvalid && q.awready) begin
      d.aw_seen = 1'b1;
      d.aw_idx = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_seen = 1'b1;
      d.w_byte = s_axi_wdata[7:0];
      d.w_lane0 = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_seen && q.w_seen && !q.bvalid) begin
      wr_go = q.w_lane0;
      d.aw_seen = 1'b0;
      d.w_seen = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      case (q.aw_idx)
        IDX_CONTROL: begin
          if (wr_go) begin
            d.control = wb;
          end
        end
        IDX_INTERRUPT: begin
          if (wr_go) begin
            keep_f = {wb[INT_GUIDE_FLAG], wb[INT_ERR_FLAG], wb[INT_BYTE_FLAG], wb[INT_END_FLAG]};
            d.enables = {wb[INT_GUIDE_EN], wb[INT_ERR_EN], wb[INT_BYTE_EN], wb[INT_END_EN]};
          end
        end
        IDX_SETUP: begin
          if (wr_go) begin
            d.guide_prescale_code = wb[SET_GPR_LSB +: 2];
            d.data_prescale_code = wb[SET_DPR_LSB +: 2];
            d.suspend_resume_flag = wb[SET_HOLD];
          end
        end
        IDX_GUIDE_W: d.gpw = wr_go ? wb : q.gpw;
        IDX_ZERO_W: d.zw = wr_go ? wb : q.zw;
        IDX_ONE_W: d.ow = wr_go ? wb : q.ow;
        IDX_HIGH_W: d.xhw = wr_go ? {wb[7], wb[5:0]} : q.xhw;
        IDX_SHIFT, IDX_DATA: d.bresp = RESP_OKAY;
        default: d.bresp = RESP_SLVERR;
      endcase
    end
    d.awready = ~d.aw_seen & ~d.bvalid;
    d.wready = ~d.w_seen & ~d.bvalid;

    // set beats a same-cycle clear
    d.flags = (q.flags & keep_f) | set_f;
    d.irq = |(d.flags & d.enables);

    // AXI4-Lite read path
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = 32'h0000_0000;
      case (s_axi_araddr[ADDR_W-1:2])
        IDX_CONTROL: d.rdata[7:0] = q.control;
        IDX_INTERRUPT: d.rdata[7:0] = {q.flags[3], q.enables[3], q.flags[2], q.enables[2],
                                       q.flags[1], q.enables[1], q.flags[0], q.enables[0]};
        IDX_SHIFT: d.rdata[7:0] = q.shift;
        IDX_DATA: d.rdata[7:0] = q.data;
        IDX_SETUP: d.rdata[7:0] = {q.guide_prescale_code, q.data_prescale_code,
                                   q.suspend_resume_flag, q.bit_counter};
        IDX_GUIDE_W: d.rdata[7:0] = q.gpw;
        IDX_ZERO_W: d.rdata[7:0] = q.zw;
        IDX_ONE_W: d.rdata[7:0] = q.ow;
        IDX_HIGH_W: d.rdata[7:0] = {q.xhw[6], 1'b0, q.xhw[5:0]};
        default: d.rresp = RESP_SLVERR;
      endcase
    end
    d.arready = ~d.rvalid;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.control <= RST_BYTE;
      q.state <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign irq = q.irq;
endmodule

// File: ir_rx_pkg.sv
// Contract
// - each filtered pulse, timed on the base clock, is judged 0, 1 or error
// - base clock chosen from 1,8,16,32,64,128,256 cycles or the subclock
// - every eighth bit moves the shift register to receive data, sets byte flag
// - end-of-frame condition of the chosen format sets the end flag
// - any set flag with its enable set raises the single interrupt
// - in hold mode only a subclock base keeps running; interrupts release hold
// - direction bit picks lsb-first or msb-first shifting
// - shift register clears on stop, guide ok, first rise (fmt 2/3), byte move
// - receive data resets to 00, changed only by byte moves
// - 3-bit bit counter counts every accepted 0 or 1 bit
// - bit counter clears on stop, guide ok, or first rise in formats 2/3
// - formats 2 and 3 ignore guide prescale code and guide widths
// - 5-bit prescaler uses guide code in guide phase, data code otherwise
// - formats 0 to 2 prescale by 4, 8, 16 or 32 ticks
// - formats 3 and 4 prescale by 2, 4, 8 or 16 ticks
// - 5-bit width counter steps on each prescaler pulse to time pulses
// - zero width sets timing points 1 and 2, one width points 3 and 4
// - high-bits register supplies bit 4 of every 5-bit width
// - formats B and C expect stop bits, B takes repeat codes
// - A half guide ppm, E full guide manchester, D manchester no guide
// - a level counts only after four equal samples on base ticks
// - polarity bit inverts input; active level at start acts as start edge
// - clearing run stops the receiver, setting it waits for the first edge
package ir_rx_pkg;
  localparam int ADDR_W = 17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register indices; byte address is four times the index
  localparam logic [14:0] IDX_CONTROL = 15'h7f96;
  localparam logic [14:0] IDX_INTERRUPT = 15'h7f97;
  localparam logic [14:0] IDX_SHIFT = 15'h7f98;
  localparam logic [14:0] IDX_DATA = 15'h7f99;
  localparam logic [14:0] IDX_SETUP = 15'h7f9a;
  localparam logic [14:0] IDX_GUIDE_W = 15'h7f9b;
  localparam logic [14:0] IDX_ZERO_W = 15'h7f9c;
  localparam logic [14:0] IDX_ONE_W = 15'h7f9d;
  localparam logic [14:0] IDX_HIGH_W = 15'h7f9e;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // receive_control fields
  localparam int CTL_RUN = 7;
  localparam int CTL_FMT_LSB = 4;
  localparam int CTL_POL = 3;
  localparam int CTL_CK_LSB = 0;
  // interrupt_flags_enables fields
  localparam int INT_GUIDE_FLAG = 7;
  localparam int INT_GUIDE_EN = 6;
  localparam int INT_ERR_FLAG = 5;
  localparam int INT_ERR_EN = 4;
  localparam int INT_BYTE_FLAG = 3;
  localparam int INT_BYTE_EN = 2;
  localparam int INT_END_FLAG = 1;
  localparam int INT_END_EN = 0;
  // bitcount_prescale_setup fields
  localparam int SET_GPR_LSB = 6;
  localparam int SET_DPR_LSB = 4;
  localparam int SET_HOLD = 3;
  // width_high_bits_direction fields
  localparam int XHW_DIR = 7;
  localparam int XHW_D1H = 5;
  localparam int XHW_D1L = 4;
  localparam int XHW_D0H = 3;
  localparam int XHW_D0L = 2;
  localparam int XHW_GPH = 1;
  localparam int XHW_GPL = 0;
  // formats
  localparam logic [2:0] FMT_A = 3'h0;
  localparam logic [2:0] FMT_B = 3'h1;
  localparam logic [2:0] FMT_C = 3'h2;
  localparam logic [2:0] FMT_D = 3'h3;
  localparam logic [2:0] FMT_E = 3'h4;
  localparam logic [2:0] CK_SUBCLOCK = 3'h6;
  localparam int FILTER_SAMPLES = 4;
  localparam logic [4:0] WIDTH_MAX = 5'h1f;
  localparam logic [5:0] WIDTH_TOL = 6'h01;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_GUIDE_HI, ST_GUIDE_LO, ST_DATA_HI, ST_DATA_LO, ST_MAN, ST_DONE
  } rx_state_e;
endpackage

// File: ir_glitch_filter.sv
`timescale 1ns/1ps
module ir_glitch_filter
  import ir_rx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sample_tick,
  input wire logic restart,
  input wire logic raw_in,
  output logic level,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic samp;
    logic [1:0] cnt;
    logic level;
    logic rise;
    logic fall;
  } filt_s;

  filt_s q, d;

  always_comb begin
    d = q;
    d.rise = 1'b0;
    d.fall = 1'b0;
    if (restart) begin
      // back to idle so an already active input reads as a start edge
      d.level = 1'b0;
      d.samp = 1'b0;
      d.cnt = 2'h0;
    end else if (sample_tick) begin
      if (raw_in != q.samp) begin
        d.samp = raw_in;
        d.cnt = 2'h0;
      end else if (q.cnt != 2'(FILTER_SAMPLES - 1)) begin
        d.cnt = q.cnt + 2'h1;
      end
      if (raw_in == q.samp && d.cnt == 2'(FILTER_SAMPLES - 1) && raw_in != q.level) begin
        d.level = raw_in;
        d.rise = raw_in;
        d.fall = ~raw_in;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.level;
  assign rise = q.rise;
  assign fall = q.fall;
endmodule

// File: infrared_remote_receiver_checker.sv
`timescale 1ns/1ps
module infrared_remote_receiver_checker
  import ir_rx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ir_rx_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped early");
  chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready during response");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read response missing");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped early");
  chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready during response");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_bad_addr: assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr[16:2]
    > IDX_HIGH_W || s_axi_araddr[16:2] < IDX_CONTROL) |-> ##[1:2] (s_axi_rvalid
    && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)) else $error("unmapped read");
  chk_good_addr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[16:2]
    <= IDX_HIGH_W && s_axi_araddr[16:2] >= IDX_CONTROL |-> ##[1:2] (s_axi_rvalid
    && s_axi_rresp == RESP_OKAY)) else $error("mapped read refused");
  // flags clear and enables change only by a bus write, which raises bvalid as irq drops
  chk_irq_sticky: assert property ($fell(irq) |-> s_axi_bvalid)
    else $error("irq fell without write");
endmodule

bind infrared_remote_receiver infrared_remote_receiver_checker chk (.core_clk, .rst_n,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);

// File: ir_remote_sender.sv
`timescale 1ns/1ps
module ir_remote_sender (
  input wire logic core_clk,
  output logic ir_out
);
  // idle low, so a start never finds the active level already present
  initial ir_out = 1'b0;
  task automatic level(input logic v, input int cycles);
    ir_out <= v;
    repeat (cycles) @(posedge core_clk);
  endtask
  // half a unit extra keeps the measured count clear of the window edge
  task automatic bit_pair(input int mark, input int space, input int unit);
    level(1'b1, mark * unit + unit / 2);
    level(1'b0, space * unit + unit / 2);
  endtask
endmodule

// File: test_infrared_remote_receiver.sv
`timescale 1ns/1ps
module test_infrared_remote_receiver;
  import ir_rx_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b1;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b1;
  logic remote_input_pin;
  logic subclock_in = 1'b0;
  logic low_power_hold = 1'b0;
  logic irq;
  logic [31:0] rd;
  logic [1:0] rsp;
  int n_errors = 0;
  int num_checks = 0;

  infrared_remote_receiver dut (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .remote_input_pin,
    .subclock_in, .low_power_hold, .irq);
  ir_remote_sender far (.core_clk, .ir_out(remote_input_pin));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // free-running subclock: one rising edge every two cycles
  always @(posedge core_clk) begin
    subclock_in <= ~subclock_in;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bready and rready stay high, so each task ends on the response edge
  task automatic wr(input logic [14:0] idx, input logic [7:0] d);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask

  task automatic rd_reg(input logic [14:0] idx);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  task automatic expect_reg(input logic [14:0] idx, input logic [7:0] exp);
    rd_reg(idx);
    check($sformatf("register %h", idx), {24'h0, exp}, rd);
  endtask

  task automatic send_bits(input logic [15:0] bits, input int n, input int u);
    for (int i = 0; i < n; i++) begin
      far.bit_pair(2, bits[i] ? 6 : 2, u);
    end
    far.bit_pair(2, 40, u);
  endtask

  task automatic reset_values();
    for (int i = 0; i < 9; i++) begin
      if (IDX_CONTROL + 15'(i) != IDX_DATA) expect_reg(IDX_CONTROL + 15'(i), RST_BYTE);
    end
    wr(IDX_SHIFT, 8'hff);
    expect_reg(IDX_SHIFT, 8'h00);
    wr(IDX_HIGH_W, 8'hff);
    expect_reg(IDX_HIGH_W, 8'hbf);
    wr(15'h7f9f, 8'h12);
    check("write resp", 32'(RESP_SLVERR), 32'(rsp));
    rd_reg(15'h7f9f);
    check("read resp", 32'(RESP_SLVERR), 32'(rsp));
  endtask

  task automatic frame_lsb_first();
    wr(IDX_HIGH_W, 8'h00);
    wr(IDX_GUIDE_W, 8'h84);
    wr(IDX_ZERO_W, 8'h22);
    wr(IDX_ONE_W, 8'h26);
    wr(IDX_INTERRUPT, 8'h55);
    wr(IDX_CONTROL, 8'h87);
    far.level(1'b1, 2);
    far.level(1'b0, 20);
    far.bit_pair(8, 4, 4);
    send_bits(16'h00a5, 8, 4);
    expect_reg(IDX_DATA, 8'ha5);
    expect_reg(IDX_INTERRUPT, 8'hdf);
    expect_reg(IDX_SHIFT, 8'h00);
    expect_reg(IDX_SETUP, 8'h00);
    check("irq", 32'h1, 32'(irq));
    wr(IDX_INTERRUPT, 8'h55);
    repeat (3) @(posedge core_clk);
    check("irq", 32'h0, 32'(irq));
    expect_reg(IDX_INTERRUPT, 8'h55);
  endtask

  // no guide in this format, so a wild guide width must not matter
  task automatic frame_msb_partial();
    wr(IDX_CONTROL, 8'h07);
    wr(IDX_INTERRUPT, 8'h00);
    wr(IDX_GUIDE_W, 8'hff);
    wr(IDX_HIGH_W, 8'h80);
    wr(IDX_SETUP, 8'h10);
    wr(IDX_CONTROL, 8'ha7);
    send_bits(16'h053c, 11, 8);
    expect_reg(IDX_DATA, 8'h3c);
    expect_reg(IDX_SHIFT, 8'h05);
    expect_reg(IDX_SETUP, 8'h13);
    expect_reg(IDX_INTERRUPT, 8'h0a);
    check("irq", 32'h0, 32'(irq));
    wr(IDX_INTERRUPT, 8'h0c);
    repeat (3) @(posedge core_clk);
    check("irq", 32'h1, 32'(irq));
    wr(IDX_CONTROL, 8'h27);
    expect_reg(IDX_SHIFT, 8'h00);
    expect_reg(IDX_SETUP, 8'h10);
  endtask

  task automatic bad_pulse();
    wr(IDX_INTERRUPT, 8'h50);
    wr(IDX_GUIDE_W, 8'h84);
    wr(IDX_HIGH_W, 8'h00);
    wr(IDX_SETUP, 8'h00);
    wr(IDX_CONTROL, 8'h80);
    far.bit_pair(8, 4, 32);
    far.bit_pair(5, 2, 32);
    far.bit_pair(2, 40, 32);
    rd_reg(IDX_INTERRUPT);
    check("guide and error flags", 32'hf0, rd & 32'hf0);
    check("irq", 32'h1, 32'(irq));
    wr(IDX_CONTROL, 8'h00);
  endtask

  // in hold the cycle-clock base must freeze, while a subclock base keeps judging
  task automatic hold_subclock();
    wr(IDX_INTERRUPT, 8'h40);
    wr(IDX_CONTROL, 8'h87);
    low_power_hold <= 1'b1;
    far.bit_pair(8, 4, 4);
    check("irq in hold on cycle base", 32'h0, 32'(irq));
    wr(IDX_CONTROL, 8'h07);
    wr(IDX_CONTROL, 8'h86);
    far.bit_pair(8, 4, 8);
    check("irq in hold on subclock", 32'h1, 32'(irq));
    low_power_hold <= 1'b0;
    wr(IDX_CONTROL, 8'h00);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #500000;
    n_errors++;
    end_sim();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    reset_values();
    frame_lsb_first();
    frame_msb_partial();
    bad_pulse();
    hold_subclock();
    end_sim();
  end
endmodule
